// >>> verilog/sfv_regs.svh
// Register map constants for the filter, volume and readback register group
// Assumes inclusion by the package and the register block only
`ifndef SFV_REGS_SVH
`define SFV_REGS_SVH

// ----------------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------------
`define SFV_OFS_CUTOFF_LOW      5'h15
`define SFV_OFS_CUTOFF_HIGH     5'h16
`define SFV_OFS_RES_ROUTING     5'h17
`define SFV_OFS_MODE_VOLUME     5'h18
`define SFV_OFS_PADDLE_X        5'h19
`define SFV_OFS_PADDLE_Y        5'h1a
`define SFV_OFS_V3_WAVE         5'h1b
`define SFV_OFS_V3_ENV          5'h1c

// ----------------------------------------------------------------------
// Fields
// ----------------------------------------------------------------------
`define SFV_CUTOFF_LOW_MSB      2
`define SFV_RES_LSB             4
`define SFV_ROUTE_V1            0
`define SFV_ROUTE_V2            1
`define SFV_ROUTE_V3            2
`define SFV_ROUTE_EXT           3
`define SFV_MODE_LP             4
`define SFV_MODE_BP             5
`define SFV_MODE_HP             6
`define SFV_MODE_V3_OFF         7
`define SFV_VOL_MSB             3

// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define SFV_RESET_BYTE          8'h00
`define SFV_PADDLE_PERIOD       512
`define SFV_RESET_HOLD          10

`endif

// >>> verilog/sfv_pkg.sv
// Types for the filter, volume and readback register group
// Assumes the constants header sits beside it
`include "sfv_regs.svh"
`default_nettype none
package sfv_pkg;
  typedef logic [7:0]  sfv_byte_t;
  typedef logic [10:0] sfv_cutoff_t;
  typedef logic [3:0]  sfv_nibble_t;
endpackage : sfv_pkg
`default_nettype wire

// >>> verilog/sfv_regs.sv
// Filter control, master level and readback register block
// Assumes sound units drive readbacks on the same clock
`include "sfv_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module sfv_regs
  import sfv_pkg::*;
#(
  parameter int PADDLE_PERIOD = `SFV_PADDLE_PERIOD
) (
  // Clock and reset
  input  wire logic  core_clk_i,
  input  wire logic  rst_i,
  // Processor bus
  input  wire logic  phase2_i,
  input  wire logic  chip_sel_n_i,
  input  wire logic  read_not_write_i,
  input  wire logic [4:0] addr_i,
  input  wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic       data_oe_o,
  // Readback sources
  input  wire logic [7:0] paddle_x_conv_i,
  input  wire logic [7:0] paddle_y_conv_i,
  input  wire logic [11:0] voice3_osc_i,
  input  wire logic [7:0] voice3_env_i,
  // Controls toward filter and mixer
  output logic [10:0] cutoff_code_o,
  output logic [3:0]  peak_emphasis_level_o,
  output logic [3:0]  filter_route_o,
  output logic        lowpass_select_o,
  output logic        bandpass_select_o,
  output logic        upper_pass_select_o,
  output logic        voice3_direct_off_o,
  output logic [3:0]  master_level_o
);

  // ----------------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------------
  // Counter is 16 bits; a period below two cannot tick cleanly
  if (PADDLE_PERIOD < 2 || PADDLE_PERIOD > 65535) begin : g_bad_period
    $error("PADDLE_PERIOD out of range");
  end

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------
  // Address comparison
  function automatic logic addr_is(input logic [4:0] addr,
                                   input logic [4:0] ofs);
    return (addr == ofs);
  endfunction : addr_is

  // Load a byte on a strobe, hold it otherwise
  function automatic sfv_byte_t load_or_hold(input logic      load,
                                             input sfv_byte_t value,
                                             input sfv_byte_t held);
    return load ? value : held;
  endfunction : load_or_hold

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  sfv_byte_t   cut_lo_reg;
  sfv_byte_t   cut_hi_reg;
  sfv_byte_t   res_route_reg;
  sfv_byte_t   mode_vol_reg;
  sfv_byte_t   pad_x_reg;
  sfv_byte_t   pad_y_reg;
  sfv_byte_t   rdata_reg;
  logic        rd_oe_reg;
  logic [15:0] pad_cnt_reg;

  sfv_byte_t   cut_lo_next;
  sfv_byte_t   cut_hi_next;
  sfv_byte_t   res_route_next;
  sfv_byte_t   mode_vol_next;
  sfv_byte_t   pad_x_next;
  sfv_byte_t   pad_y_next;
  sfv_byte_t   rdata_next;
  logic        rd_oe_next;
  logic [15:0] pad_cnt_next;
  sfv_byte_t   rd_mux;

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  wire logic access_ok = ~chip_sel_n_i & phase2_i;
  wire logic wr_en     = access_ok & ~read_not_write_i;
  wire logic rd_en     = access_ok & read_not_write_i;

  // Only the four control locations take writes
  wire logic wr_cut_lo    = wr_en & addr_is(addr_i, `SFV_OFS_CUTOFF_LOW);
  wire logic wr_cut_hi    = wr_en & addr_is(addr_i, `SFV_OFS_CUTOFF_HIGH);
  wire logic wr_res_route = wr_en & addr_is(addr_i, `SFV_OFS_RES_ROUTING);
  wire logic wr_mode_vol  = wr_en & addr_is(addr_i, `SFV_OFS_MODE_VOLUME);

  // ----------------------------------------------------------------------
  // Control next values
  // ----------------------------------------------------------------------
  assign cut_lo_next    = load_or_hold(wr_cut_lo, data_i, cut_lo_reg);
  assign cut_hi_next    = load_or_hold(wr_cut_hi, data_i, cut_hi_reg);
  assign res_route_next = load_or_hold(wr_res_route, data_i, res_route_reg);
  assign mode_vol_next  = load_or_hold(wr_mode_vol, data_i, mode_vol_reg);

  // ----------------------------------------------------------------------
  // Paddle next values
  // ----------------------------------------------------------------------
  // Readings stay valid between samples; only the period tick reloads them
  wire logic pad_tick = (pad_cnt_reg == 16'(PADDLE_PERIOD - 1));

  assign pad_cnt_next = pad_tick ? 16'h0000 : pad_cnt_reg + 16'h0001;
  assign pad_x_next   = load_or_hold(pad_tick, paddle_x_conv_i, pad_x_reg);
  assign pad_y_next   = load_or_hold(pad_tick, paddle_y_conv_i, pad_y_reg);

  // ----------------------------------------------------------------------
  // Cutoff low register
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cut_lo_reg <= `SFV_RESET_BYTE;
    end else begin
      cut_lo_reg <= cut_lo_next;
    end
  end

  // ----------------------------------------------------------------------
  // Cutoff high register
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cut_hi_reg <= `SFV_RESET_BYTE;
    end else begin
      cut_hi_reg <= cut_hi_next;
    end
  end

  // ----------------------------------------------------------------------
  // Resonance and routing register
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      res_route_reg <= `SFV_RESET_BYTE;
    end else begin
      res_route_reg <= res_route_next;
    end
  end

  // ----------------------------------------------------------------------
  // Mode and level register
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      mode_vol_reg <= `SFV_RESET_BYTE;
    end else begin
      mode_vol_reg <= mode_vol_next;
    end
  end

  // ----------------------------------------------------------------------
  // Paddle period counter
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pad_cnt_reg <= 16'h0000;
    end else begin
      pad_cnt_reg <= pad_cnt_next;
    end
  end

  // ----------------------------------------------------------------------
  // Paddle readings
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pad_x_reg <= `SFV_RESET_BYTE;
    end else begin
      pad_x_reg <= pad_x_next;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pad_y_reg <= `SFV_RESET_BYTE;
    end else begin
      pad_y_reg <= pad_y_next;
    end
  end

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  always_comb begin
    unique case (addr_i)
      `SFV_OFS_PADDLE_X: rd_mux = pad_x_reg;
      `SFV_OFS_PADDLE_Y: rd_mux = pad_y_reg;
      `SFV_OFS_V3_WAVE:  rd_mux = voice3_osc_i[11:4];
      `SFV_OFS_V3_ENV:   rd_mux = voice3_env_i;
      default:           rd_mux = 8'h00;
    endcase
  end

  // Live readbacks are captured at the edge that takes the read
  assign rdata_next = load_or_hold(rd_en, rd_mux, rdata_reg);
  assign rd_oe_next = rd_en;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rdata_reg <= `SFV_RESET_BYTE;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rd_oe_reg <= 1'b0;
    end else begin
      rd_oe_reg <= rd_oe_next;
    end
  end

  // ----------------------------------------------------------------------
  // Data bus drive
  // ----------------------------------------------------------------------
  // Drive drops in the same cycle as the strobe, so the bus is never held

  assign data_o    = rdata_reg;
  assign data_oe_o = rd_oe_reg & rd_en;

  // ----------------------------------------------------------------------
  // Control outputs
  // ----------------------------------------------------------------------
  assign cutoff_code_o         = {cut_hi_reg, cut_lo_reg[`SFV_CUTOFF_LOW_MSB:0]};
  assign peak_emphasis_level_o = res_route_reg[7:`SFV_RES_LSB];
  assign filter_route_o        = res_route_reg[`SFV_ROUTE_EXT:`SFV_ROUTE_V1];
  assign lowpass_select_o      = mode_vol_reg[`SFV_MODE_LP];
  assign bandpass_select_o     = mode_vol_reg[`SFV_MODE_BP];
  assign upper_pass_select_o   = mode_vol_reg[`SFV_MODE_HP];
  assign voice3_direct_off_o   = mode_vol_reg[`SFV_MODE_V3_OFF];
  assign master_level_o        = mode_vol_reg[`SFV_VOL_MSB:0];

endmodule : sfv_regs
`default_nettype wire

// >>> tb/sfv_host.sv
// Processor-side bus model for the register group
// Assumes the bench calls xfer once the reset has been released
`timescale 1ns/10ps
`default_nettype none
module sfv_host (
  // Clock
  input  wire logic  core_clk_i,
  // Bus toward the block
  output logic       phase2_i,
  output logic       chip_sel_n_i,
  output logic       read_not_write_i,
  output logic [4:0] addr_i,
  output logic [7:0] data_i
);
  initial {phase2_i, chip_sel_n_i, read_not_write_i, addr_i, data_i} = 16'h6000;
  // Selected and strobed only while transferring
  task automatic xfer(input logic r, input logic [4:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    #1 {phase2_i, chip_sel_n_i, read_not_write_i, addr_i, data_i} = {2'b10, r, a, d};
    repeat (1 + r) @(posedge core_clk_i);
    #1 {phase2_i, chip_sel_n_i, data_i} = {2'b01, ~d};
  endtask : xfer
endmodule : sfv_host
`default_nettype wire

// >>> tb/sfv_regs_chk.sv
// Timing assertions for the register group
// Assumes a bind onto sfv_regs with ports of the same names
`timescale 1ns/10ps
`default_nettype none
module sfv_regs_chk (
  // Clock, reset, bus and voice 3 readbacks
  input wire logic        core_clk_i, rst_i, phase2_i, chip_sel_n_i, read_not_write_i,
  input wire logic        data_oe_o,
  input wire logic [4:0]  addr_i,
  input wire logic [7:0]  data_i, data_o, voice3_env_i,
  input wire logic [11:0] voice3_osc_i,
  // Controls
  input wire logic [10:0] cutoff_code_o,
  input wire logic [3:0]  peak_emphasis_level_o, filter_route_o, master_level_o,
  input wire logic        lowpass_select_o, bandpass_select_o, upper_pass_select_o,
  input wire logic        voice3_direct_off_o
);
  wire rd = phase2_i & ~chip_sel_n_i & read_not_write_i;
  wire wr = phase2_i & ~chip_sel_n_i & ~read_not_write_i;
  wire [7:0] mode = {voice3_direct_off_o, upper_pass_select_o, bandpass_select_o,
    lowpass_select_o, master_level_o};
  wire [26:0] ctl = {cutoff_code_o, peak_emphasis_level_o, filter_route_o, mode};
  logic [7:0] d_reg, osc_reg, env_reg;
  always_ff @(posedge core_clk_i) {d_reg, osc_reg, env_reg} <= {data_i, voice3_osc_i[11:4],
    voice3_env_i};
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  a_cut_low: assert property (wr && addr_i == 5'h15
    |=> cutoff_code_o[2:0] == d_reg[2:0]) else $error("cutoff low wrong");
  a_cut_high: assert property (wr && addr_i == 5'h16
    |=> cutoff_code_o[10:3] == d_reg) else $error("cutoff high wrong");
  a_res_route: assert property (wr && addr_i == 5'h17
    |=> {peak_emphasis_level_o, filter_route_o} == d_reg) else $error("routing wrong");
  a_mode_vol: assert property (wr && addr_i == 5'h18
    |=> mode == d_reg) else $error("mode wrong");
  a_ctl_hold: assert property (!(wr && addr_i inside {[5'h15:5'h18]})
    |=> $stable(ctl)) else $error("control moved");
  a_osc_read: assert property (rd && addr_i == 5'h1b
    |=> data_o == osc_reg) else $error("wave read wrong");
  a_env_read: assert property (rd && addr_i == 5'h1c
    |=> data_o == env_reg) else $error("envelope read wrong");
  a_unused_read: assert property (rd && addr_i > 5'h1c
    |=> data_o == 8'h00) else $error("unused read wrong");
  a_oe_read: assert property (rd ##1 rd |-> data_oe_o) else $error("no drive");
  a_oe_idle: assert property (!rd |-> !data_oe_o) else $error("stray drive");
  a_reset_clear: assert property (disable iff (1'b0) rst_i
    |=> ctl == 27'h0 && !data_oe_o) else $error("reset not clear");
  c_paddle: cover property (rd && addr_i == 5'h19);
  c_mode: cover property (wr && addr_i == 5'h18);
  c_read: cover property (rd ##1 rd);
endmodule : sfv_regs_chk
bind sfv_regs sfv_regs_chk u_chk (.*);
`default_nettype wire

// >>> tb/test_synth_filter_volume_readback_regs.sv
// Self-checking bench for the register group
// Assumes sfv_host drives the bus and the checker is bound
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin num_errors++; \
  $display("unexpected %0t %h %h", $time, a, e); end end
module test_synth_filter_volume_readback_regs;
  import sfv_pkg::*;
  localparam int P = 8;
  logic core_clk_i = 0, rst_i = 1, phase2_i, chip_sel_n_i, read_not_write_i, data_oe_o;
  logic lowpass_select_o, bandpass_select_o, upper_pass_select_o, voice3_direct_off_o;
  logic [4:0] addr_i;
  logic [11:0] voice3_osc_i;
  sfv_byte_t data_i, data_o, paddle_x_conv_i, paddle_y_conv_i, voice3_env_i;
  sfv_byte_t lo = 0, hi = 0, rr = 0, mv = 0;
  sfv_cutoff_t cutoff_code_o;
  sfv_nibble_t peak_emphasis_level_o, filter_route_o, master_level_o;
  int num_errors = 0, cmp_count = 0;
  sfv_byte_t exp_q[$];
  sfv_byte_t exp_v;
  logic oe_d = 0;
  wire [26:0] ctl = {cutoff_code_o, peak_emphasis_level_o, filter_route_o, voice3_direct_off_o,
    upper_pass_select_o, bandpass_select_o, lowpass_select_o, master_level_o};
  always #5 core_clk_i = ~core_clk_i;
  sfv_host host (.*);
  sfv_regs #(.PADDLE_PERIOD(P)) uut (.*);
  // Oldest note against each new read result
  always @(posedge core_clk_i) begin
    if (data_oe_o === 1'b1 && !oe_d) begin
      exp_v = exp_q.pop_front();
      `CHK(data_o, exp_v)
    end
    oe_d <= data_oe_o;
  end
  task automatic rd(input logic [4:0] a, input sfv_byte_t e);
    exp_q.push_back(e);
    host.xfer(1'b1, a, ~e);
  endtask : rd
  task automatic wr(input logic [4:0] a, input sfv_byte_t d);
    case (a) 5'h15: lo = d; 5'h16: hi = d; 5'h17: rr = d; 5'h18: mv = d; default: ; endcase
    host.xfer(1'b0, a, d);
    `CHK(ctl, {hi, lo[2:0], rr, mv})
  endtask : wr
  task finish_test;
    if (num_errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  // Watchdog well beyond the roughly 130 cycles of the sequence
  initial begin
    #20000;
    num_errors++;
    finish_test();
  end
  initial begin
    void'($urandom(82396));
    {paddle_x_conv_i, paddle_y_conv_i, voice3_env_i} = 24'($urandom);
    voice3_osc_i = 12'($urandom);
    repeat (12) @(posedge core_clk_i);
    #1 rst_i = 0;
    rd(5'h19, 8'h00);
    repeat (2 * P) @(posedge core_clk_i);
    rd(5'h19, paddle_x_conv_i);
    rd(5'h1a, paddle_y_conv_i);
    wr(5'h17, 8'hf7);
    wr(5'h18, 8'h5f);
    for (int i = 0; i < 24; i++) wr(5'h15 + 5'($urandom % 11), 8'($urandom));
    repeat (4) begin
      {voice3_osc_i, voice3_env_i} = 20'($urandom);
      rd(5'h1b, voice3_osc_i[11:4]);
      rd(5'h1c, voice3_env_i);
    end
    rd(5'h1e, 8'h00);
    rd(5'h16, 8'h00);
    #1 rst_i = 1;
    repeat (12) @(posedge core_clk_i);
    `CHK(ctl, 27'h0)
    finish_test();
  end
endmodule : test_synth_filter_volume_readback_regs
`default_nettype wire
